// ---- logic/fq_host.sv ----
// host controller for flash identifier, status and query reads
//
// What this block does
// - any other command except 50H leaves id mode
// - block status trusted only when ready
// - strobe falls to latch, rises before next
// - reissue multi-write command to refresh extended status
// - clear command is single write of 50H
//
// Local design decision: the plain strobed port.
`timescale 1ns/100ps
module fq_host #(
  parameter int AW        = 21,
  parameter int BLK_SHIFT = 15
) (
  // clock and reset
  input  wire logic          clk_in,
  input  wire logic          rst_n_in,
  // software port
  input  wire logic [3:0]    reg_addr_in,
  input  wire logic [31:0]   reg_wdata_in,
  input  wire logic          reg_wr_in,
  input  wire logic          reg_rd_in,
  output logic [31:0]        reg_rdata_out,
  // flash pins
  output logic [AW-1:0]      flash_addr_out,
  output logic [15:0]        flash_dq_out,
  output logic               flash_dq_oe_out,
  input  wire logic [15:0]   flash_dq_in,
  output logic               flash_bank_enable_n_out,
  output logic               flash_oe_n_out,
  output logic               flash_we_n_out,
  output logic               flash_byte_n_out,
  output logic               flash_reset_powerdown_n_out
);
  typedef enum logic [2:0] {S_IDLE, S_CMD, S_CMD_WAIT, S_RD, S_RD_WAIT, S_SR, S_SR_WAIT} fq_st_t;
  typedef struct packed {
    fq_st_t           st;
    fq_pkg::fq_mode_t mode;
    fq_pkg::fq_op_t   op;
    logic             byte_mode;
    logic [AW-1:0]    addr;
    logic [7:0]       cmd;
    logic             req;
    logic [15:0]      rdata;
    logic [7:0]       sr;
    logic [7:0]       blk;
    logic             blk_valid;
    logic             ignored;
    logic             done;
    logic             rd_pend;
    logic [31:0]      rout;
  } fq_st_all_t;
  fq_st_all_t q, d;

  fq_cyc_if #(.AW(AW)) cyc ();
  logic [15:0] merged;

  fq_pin_engine #(.AW(AW)) u_eng (
    .clk_in                  (clk_in),
    .rst_n_in                (rst_n_in),
    .cyc                     (cyc.eng),
    .flash_addr_out          (flash_addr_out),
    .flash_dq_out            (flash_dq_out),
    .flash_dq_oe_out         (flash_dq_oe_out),
    .flash_dq_in             (flash_dq_in),
    .flash_bank_enable_n_out (flash_bank_enable_n_out),
    .flash_oe_n_out          (flash_oe_n_out),
    .flash_we_n_out          (flash_we_n_out)
  );

  fq_byte_merge u_merge (
    .byte_mode_in (q.byte_mode),
    .query_in     (q.mode == fq_pkg::FQ_MODE_QUERY),
    .raw_in       (cyc.rdata),
    .word_out     (merged)
  );

  function automatic logic [AW-1:0] blk_base(input logic [AW-1:0] a);
    blk_base = (a >> BLK_SHIFT) << BLK_SHIFT;
  endfunction

  // read-cycle address for the current operation; byte mode doubles word offsets
  function automatic logic [AW-1:0] rd_addr(input fq_pkg::fq_op_t op, input fq_pkg::fq_mode_t m,
                                            input logic [AW-1:0] a, input logic bm);
    logic [AW-1:0] w;
    w = a;
    if (op == fq_pkg::FQ_OP_BLOCK_STATUS) begin
      if (m == fq_pkg::FQ_MODE_QUERY) begin
        w = blk_base(a) | AW'(fq_pkg::QRY_OFS_BLKSTAT);
      end else begin
        w = blk_base(a) | AW'({fq_pkg::ID_OFS_BLKSTAT, 1'b0});
      end
    end
    if (bm) begin
      w = AW'({w, 1'b0});
      if (m == fq_pkg::FQ_MODE_QUERY) begin
        w[0] = 1'b0;
      end
    end
    rd_addr = w;
  endfunction

  always_comb begin
    d = q;
    d.req = 1'b0;
    d.rd_pend = 1'b0;
    if (q.rd_pend) begin
      d.rout = 32'h0000_0000;
    end
    if (reg_rd_in) begin
      d.rd_pend = 1'b1;
      unique case (reg_addr_in)
        fq_pkg::REG_CTRL:    d.rout = {29'h0, q.byte_mode, 2'(q.mode)};
        fq_pkg::REG_ADDR:    d.rout = 32'(q.addr);
        fq_pkg::REG_STATUS:  d.rout = {20'h0, q.ignored, q.blk_valid, q.done, q.st == S_IDLE, q.sr};
        fq_pkg::REG_RDATA:   d.rout = {16'h0, q.rdata};
        fq_pkg::REG_BLKSTAT: d.rout = {24'h0, q.blk};
        default:             d.rout = 32'h0000_0000;
      endcase
    end
    if (reg_wr_in && reg_addr_in == fq_pkg::REG_ADDR) begin
      d.addr = reg_wdata_in[AW-1:0];
    end
    unique case (q.st)
      S_IDLE: begin
        if (reg_wr_in && reg_addr_in == fq_pkg::REG_CTRL) begin
          d.op = fq_pkg::fq_op_t'(reg_wdata_in[2:0]);
          d.byte_mode = reg_wdata_in[8];
          d.done = 1'b0;
          d.ignored = 1'b0;
          unique case (fq_pkg::fq_op_t'(reg_wdata_in[2:0]))
            fq_pkg::FQ_OP_ENTER_ID:    begin d.cmd = fq_pkg::CMD_READ_ID; d.st = S_CMD; end
            fq_pkg::FQ_OP_ENTER_QUERY: begin d.cmd = fq_pkg::CMD_QUERY; d.st = S_CMD; end
            fq_pkg::FQ_OP_READ_STATUS: begin d.cmd = fq_pkg::CMD_READ_STATUS; d.st = S_CMD; end
            fq_pkg::FQ_OP_READ_EXT:    begin d.cmd = fq_pkg::CMD_MULTI_WRITE; d.st = S_CMD; end
            fq_pkg::FQ_OP_READ_ARRAY:  begin d.cmd = fq_pkg::CMD_READ_ARRAY; d.st = S_CMD; end
            fq_pkg::FQ_OP_CLEAR_STATUS: begin
              // device drops it while busy, so check ready first
              d.cmd = fq_pkg::CMD_READ_STATUS;
              d.st = S_CMD;
            end
            default: begin d.st = S_RD; end
          endcase
        end
      end
      S_CMD: begin
        d.req = 1'b1;
        d.st = S_CMD_WAIT;
      end
      S_CMD_WAIT: begin
        if (cyc.done) begin
          unique case (q.cmd)
            fq_pkg::CMD_READ_ID:     d.mode = fq_pkg::FQ_MODE_ID;
            fq_pkg::CMD_QUERY:       d.mode = fq_pkg::FQ_MODE_QUERY;
            fq_pkg::CMD_READ_STATUS: d.mode = fq_pkg::FQ_MODE_STATUS;
            // clearing flags leaves the device in its current read mode
            fq_pkg::CMD_CLEAR_STAT:  d.mode = q.mode;
            default:                 d.mode = fq_pkg::FQ_MODE_ARRAY;
          endcase
          if (q.op == fq_pkg::FQ_OP_CLEAR_STATUS && q.cmd == fq_pkg::CMD_READ_STATUS) begin
            d.st = S_SR;
          end else if (q.op == fq_pkg::FQ_OP_READ_STATUS || q.op == fq_pkg::FQ_OP_READ_EXT) begin
            d.st = S_RD;
          end else begin
            d.st = S_IDLE;
            d.done = 1'b1;
          end
        end
      end
      S_SR: begin
        d.req = 1'b1;
        d.st = S_SR_WAIT;
      end
      S_SR_WAIT: begin
        if (cyc.done) begin
          d.sr = cyc.rdata[7:0];
          if (cyc.rdata[fq_pkg::SR_READY_BIT]) begin
            d.cmd = fq_pkg::CMD_CLEAR_STAT;
            d.st = S_CMD;
            d.op = fq_pkg::FQ_OP_READ_ARRAY;
            d.mode = fq_pkg::FQ_MODE_STATUS;
          end else begin
            d.ignored = 1'b1;
            d.done = 1'b1;
            d.st = S_IDLE;
          end
        end
      end
      S_RD: begin
        d.req = 1'b1;
        d.st = S_RD_WAIT;
      end
      S_RD_WAIT: begin
        if (cyc.done) begin
          d.rdata = merged;
          if (q.mode == fq_pkg::FQ_MODE_STATUS) begin
            d.sr = merged[7:0];
          end
          if (q.op == fq_pkg::FQ_OP_BLOCK_STATUS) begin
            // reserved bits masked off
            d.blk = merged[7:0] & fq_pkg::BLK_VALID_MASK;
            d.blk_valid = q.sr[fq_pkg::SR_READY_BIT];
          end
          d.done = 1'b1;
          d.st = S_IDLE;
        end
      end
      default: d.st = S_IDLE;
    endcase
  end

  assign cyc.req      = q.req;
  assign cyc.is_write = (q.st == S_CMD) || (q.st == S_CMD_WAIT);
  assign cyc.addr     = cyc.is_write ? q.addr : rd_addr(q.op, q.mode, q.addr, q.byte_mode);
  assign cyc.wdata    = {8'h00, q.cmd};

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_out               = q.rout;
  assign flash_byte_n_out            = !q.byte_mode;
  assign flash_reset_powerdown_n_out = rst_n_in;
endmodule // fq_host

// ---- logic/fq_pkg.sv ----
// constants and types for the flash identifier and status query host
package fq_pkg;
  localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
  localparam logic [7:0] CMD_READ_ID     = 8'h90;
  localparam logic [7:0] CMD_QUERY       = 8'h98;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STAT  = 8'h50;
  localparam logic [7:0] CMD_MULTI_WRITE = 8'hE8;
  // identifier-mode word offsets
  localparam logic [1:0] ID_OFS_MANUF    = 2'h0;
  localparam logic [1:0] ID_OFS_DEVICE   = 2'h1;
  localparam logic [1:0] ID_OFS_BLKSTAT  = 2'h2;
  // query-mode block status word offset (BA+2)
  localparam logic [3:0] QRY_OFS_BLKSTAT = 4'h2;
  // status bit positions
  localparam int BLK_LOCK_BIT     = 0;
  localparam int BLK_ERASE_BIT    = 1;
  localparam int SR_READY_BIT     = 7;
  localparam int SR_ERASE_FAIL    = 5;
  localparam int SR_WRITE_FAIL    = 4;
  localparam int SR_VPP_FAIL      = 3;
  localparam int SR_LOCK_FAIL     = 1;
  localparam logic [7:0] SR_STICKY_MASK = 8'h3A;
  localparam logic [7:0] BLK_VALID_MASK = 8'h03;
  // host register offsets (word index on the software port)
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_ADDR     = 4'h1;
  localparam logic [3:0] REG_STATUS   = 4'h2;
  localparam logic [3:0] REG_RDATA    = 4'h3;
  localparam logic [3:0] REG_BLKSTAT  = 4'h4;
  // timing
  localparam int CLK_NS       = 25;
  localparam int STROBE_NS    = 100;
  localparam int RECOVER_NS   = 50;
  localparam int STROBE_CYC   = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOVER_CYC  = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
  // software operations
  typedef enum logic [2:0] {
    FQ_OP_ENTER_ID, FQ_OP_ENTER_QUERY, FQ_OP_READ_STATUS, FQ_OP_CLEAR_STATUS,
    FQ_OP_READ_EXT, FQ_OP_READ_ARRAY, FQ_OP_READ, FQ_OP_BLOCK_STATUS
  } fq_op_t;
  typedef enum logic [1:0] {FQ_MODE_ARRAY, FQ_MODE_ID, FQ_MODE_STATUS, FQ_MODE_QUERY} fq_mode_t;
endpackage

// ---- logic/fq_cyc_if.sv ----
// bundle between sequencer and pin cycle engine
`timescale 1ns/100ps
interface fq_cyc_if #(parameter int AW = 21);
  logic          req;
  logic          is_write;
  logic [AW-1:0] addr;
  logic [15:0]   wdata;
  logic          done;
  logic [15:0]   rdata;
  modport seq (output req, output is_write, output addr, output wdata, input done, input rdata);
  modport eng (input req, input is_write, input addr, input wdata, output done, output rdata);
endinterface

// ---- logic/fq_pin_engine.sv ----
// one asynchronous write or read cycle on the flash pins
`timescale 1ns/100ps
module fq_pin_engine #(
  parameter int AW = 21
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // sequencer side
  fq_cyc_if.eng            cyc,
  // flash pins
  output logic [AW-1:0]    flash_addr_out,
  output logic [15:0]      flash_dq_out,
  output logic             flash_dq_oe_out,
  input  wire logic [15:0] flash_dq_in,
  output logic             flash_bank_enable_n_out,
  output logic             flash_oe_n_out,
  output logic             flash_we_n_out
);
  typedef enum logic [1:0] {E_IDLE, E_STROBE, E_RECOVER} fq_eng_st_t;
  typedef struct packed {
    fq_eng_st_t    st;
    logic [7:0]    cnt;
    logic          wr;
    logic [AW-1:0] addr;
    logic [15:0]   wd;
    logic [15:0]   rd;
    logic [15:0]   s1;
    logic [15:0]   s2;
    logic          done;
  } fq_eng_t;
  fq_eng_t q, d;
  logic    strobe_on;

  always_comb begin
    d = q;
    d.done = 1'b0;
    d.s1 = flash_dq_in;
    d.s2 = q.s1;
    unique case (q.st)
      E_IDLE: begin
        if (cyc.req) begin
          d.st = E_STROBE;
          d.wr = cyc.is_write;
          d.addr = cyc.addr;
          d.wd = cyc.wdata;
          // first strobe-state cycle only sets up the address, so the device never sees it move under a falling enable
          d.cnt = 8'(fq_pkg::STROBE_CYC + 3);
        end
      end
      E_STROBE: begin
        if (q.cnt == 8'h00) begin
          // capture at end of strobe; the latch is refreshed because strobe always rises after
          d.rd = q.s2;
          d.st = E_RECOVER;
          d.cnt = 8'(fq_pkg::RECOVER_CYC);
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      E_RECOVER: begin
        if (q.cnt == 8'h00) begin
          d.st = E_IDLE;
          d.done = 1'b1;
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      default: d.st = E_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // strobes drop for every cycle and return high in recovery
  assign flash_addr_out          = q.addr;
  assign flash_dq_out            = q.wd;
  assign flash_dq_oe_out         = (q.st != E_IDLE) && q.wr;
  assign strobe_on               = (q.st == E_STROBE) && (q.cnt != 8'(fq_pkg::STROBE_CYC + 3));
  assign flash_bank_enable_n_out = !strobe_on;
  assign flash_oe_n_out          = !(strobe_on && !q.wr);
  assign flash_we_n_out          = !(strobe_on && q.wr);
  assign cyc.done                = q.done;
  assign cyc.rdata               = q.rd;
endmodule // fq_pin_engine

// ---- logic/fq_byte_merge.sv ----
// forms the read word for the selected bus width
`timescale 1ns/100ps
module fq_byte_merge (
  // mode
  input  wire logic        byte_mode_in,
  input  wire logic        query_in,
  // data
  input  wire logic [15:0] raw_in,
  output logic [15:0]      word_out
);
  always_comb begin
    word_out = raw_in;
    // query bytes live on the low lane only; high lane is undriven or 00H
    if (query_in || byte_mode_in) begin
      word_out = {8'h00, raw_in[7:0]};
    end
  end
endmodule // fq_byte_merge

// ---- bench/fq_host_checker.sv ----
// pin timing assertions for the flash identifier and status query host
`timescale 1ns/100ps
module fq_host_checker #(
  parameter int AW = 21
) (
  // clock and reset
  input wire logic          clk_in,
  input wire logic          rst_n_in,
  // flash pins
  input wire logic [AW-1:0] flash_addr_out,
  input wire logic [15:0]   flash_dq_out,
  input wire logic          flash_dq_oe_out,
  input wire logic          flash_bank_enable_n_out,
  input wire logic          flash_oe_n_out,
  input wire logic          flash_we_n_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // strobe low time is STROBE_CYC+3 cycles
  sequence rd_hold;
    !flash_oe_n_out [*7];
  endsequence
  sequence wr_hold;
    !flash_we_n_out [*7];
  endsequence
  // recovery of RECOVER_CYC+1 cycles lets the device relatch
  sequence recover;
    (flash_oe_n_out && flash_we_n_out) [*3];
  endsequence

  rd_width_a: assert property ($fell(flash_oe_n_out) |-> rd_hold)
    else $error("read strobe width wrong");
  wr_width_a: assert property ($fell(flash_we_n_out) |-> wr_hold)
    else $error("write strobe width wrong");
  strobe_recover_a: assert property ($rose(flash_oe_n_out) || $rose(flash_we_n_out) |-> recover)
    else $error("strobe recovery too short");
  cmd_drive_a: assert property (!flash_we_n_out |-> flash_dq_oe_out && flash_dq_out[15:8] == 8'h00)
    else $error("command byte not driven");
  cmd_stable_a: assert property (!flash_we_n_out && !$past(flash_we_n_out) |-> $stable(flash_dq_out))
    else $error("command data moved in strobe");
  no_fight_a: assert property (!flash_oe_n_out |-> !flash_dq_oe_out && flash_we_n_out)
    else $error("bus driven during read");
  bank_sel_a: assert property (!(flash_oe_n_out && flash_we_n_out) |-> !flash_bank_enable_n_out)
    else $error("strobe without bank enable");
  addr_hold_a: assert property (!flash_oe_n_out && !$past(flash_oe_n_out) |-> $stable(flash_addr_out))
    else $error("address moved in read");
  addr_setup_a: assert property ($fell(flash_bank_enable_n_out) |-> $stable(flash_addr_out))
    else $error("address moved as bank enable fell");
endmodule // fq_host_checker

// ---- bench/fq_flash_model.sv ----
// behavioural flash device for identifier, status and query reads
`timescale 1ns/100ps
module fq_flash_model #(
  parameter int         AW    = 21,
  parameter int         BS    = 15,
  parameter logic [7:0] MANUF = 8'h5A, // arbitrary value
  parameter logic [7:0] DEVID = 8'hC3  // arbitrary value
) (
  // pins
  input  wire logic [AW-1:0] addr_in,
  input  wire logic [15:0]   bus_in,
  output logic [15:0]        dq_out,
  input  wire logic          bank_enable_n_in,
  input  wire logic          oe_n_in,
  input  wire logic          we_n_in,
  input  wire logic          byte_n_in,
  input  wire logic          reset_powerdown_n_in,
  // scenario controls
  input  wire logic          busy_in,
  input  wire logic          fail_in,
  input  wire logic [7:0]    ext_in
);
  logic [7:0]    cmd_q, sticky_q, ext_q, wd_q, sr, blk;
  logic [15:0]   lat_q;
  logic [AW-1:0] wa;
  wire           rd_n = oe_n_in | bank_enable_n_in;
  assign wa  = byte_n_in ? addr_in : addr_in >> 1;
  assign sr  = {~busy_in, 7'h00} | sticky_q;
  assign blk = {~wa[BS+5:BS], wa[BS+1] ^ wa[BS+2], wa[BS]};
  function automatic logic [7:0] qbyte(input logic [BS-1:0] off);
    case (off)
      'h2:     return blk;
      'h10:    return 8'h51;
      'h11:    return 8'h52;
      'h12:    return 8'h59;
      default: return 8'h00;
    endcase
  endfunction
  // data may move in the same step as the rising strobe
  always @(bus_in or we_n_in) if (!we_n_in) wd_q = bus_in[7:0];
  always @(posedge we_n_in or posedge fail_in or negedge reset_powerdown_n_in) begin
    if (!reset_powerdown_n_in) begin
      cmd_q    <= 8'hFF;
      sticky_q <= 8'h00;
      ext_q    <= 8'h00;
    end else if (fail_in) begin
      sticky_q <= sticky_q | 8'h3A;
    end else begin
      if (wd_q == 8'h50) begin
        if (!busy_in) sticky_q <= 8'h00;
      end else cmd_q <= wd_q;
      if (wd_q == 8'hE8) ext_q <= ext_in;
    end
  end
  always @(negedge rd_n) begin
    case (cmd_q)
      8'h90:   lat_q <= {8'h00, wa[2] ? blk : (wa[1] ? DEVID : MANUF)};
      8'h98:   lat_q <= {8'h00, qbyte(wa[BS-1:0])};
      8'h70:   lat_q <= {8'h00, sr};
      8'hE8:   lat_q <= {8'h00, ext_q};
      default: lat_q <= wa[15:0] ^ 16'hA5A5;
    endcase
  end
  // released lines show the inverse of the last value
  assign dq_out = rd_n ? ~lat_q : {byte_n_in ? lat_q[15:8] : ~lat_q[15:8], lat_q[7:0]};
endmodule // fq_flash_model

// ---- bench/test_fq_host.sv ----
// self-checking bench for the flash identifier and status query host
`timescale 1ns/100ps
module test_fq_host;
  localparam int AW = 21;
  localparam logic [15:0] ID_MAN = 16'h005A; // arbitrary value
  localparam logic [15:0] ID_DEV = 16'h00C3; // arbitrary value
  logic          clk_in, rst_n_in, reg_wr_in, reg_rd_in, busy, fail, byte_m;
  logic [3:0]    reg_addr_in;
  logic [31:0]   reg_wdata_in, reg_rdata_out, s, d;
  logic [AW-1:0] fa, qa;
  logic [15:0]   fdo, fdi, mdq;
  logic          foe, fbe, frd, fwe, fbyte, frp;
  logic [7:0]    ext;
  logic [5:0]    b;
  int            failures, check_count, seed;
  fq_host u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .flash_addr_out(fa),
    .flash_dq_out(fdo), .flash_dq_oe_out(foe), .flash_dq_in(fdi), .flash_bank_enable_n_out(fbe),
    .flash_oe_n_out(frd), .flash_we_n_out(fwe), .flash_byte_n_out(fbyte), .flash_reset_powerdown_n_out(frp));
  fq_flash_model #(.MANUF(ID_MAN[7:0]), .DEVID(ID_DEV[7:0])) u_flash (.addr_in(fa), .bus_in(fdi), .dq_out(mdq),
    .bank_enable_n_in(fbe), .oe_n_in(frd), .we_n_in(fwe), .byte_n_in(fbyte), .reset_powerdown_n_in(frp),
    .busy_in(busy), .fail_in(fail), .ext_in(ext));
  assign fdi = foe ? fdo : mdq;
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  function automatic logic [15:0] exp_blk(input logic [5:0] k);
    return {14'h0, k[1] ^ k[2], k[0]};
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= v;
    reg_wr_in    <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 v = reg_rdata_out;
  endtask
  // one software operation, then its status and read word
  task automatic op(input logic [2:0] o, input logic [AW-1:0] a);
    wr(fq_pkg::REG_ADDR, 32'(a));
    wr(fq_pkg::REG_CTRL, {23'h0, byte_m, 5'h0, o});
    s = 32'h0;
    for (int i = 0; i < 100 && s[8] !== 1'b1; i++) rd(fq_pkg::REG_STATUS, s);
    chk("op finished", 16'h3, {14'h0, s[9:8]});
    rd(fq_pkg::REG_RDATA, d);
  endtask
  task automatic pulse_fail();
    @(posedge clk_in);
    fail <= 1'b1;
    @(posedge clk_in);
    fail <= 1'b0;
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #(25 * 60000);
    failures++;
    wrap_up();
  end
  initial begin
    {rst_n_in, reg_wr_in, reg_rd_in, busy, fail, byte_m} = 6'h00;
    reg_addr_in  = 4'h0;
    reg_wdata_in = 32'h0;
    ext          = 8'h80;
    seed         = 32'h445c5b44;
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(fq_pkg::REG_STATUS, s);
    chk("idle after reset", 16'h1, {15'h0, s[8]});
    rd(4'hF, s);
    chk("unmapped read", 16'h0, s[15:0]);
    op(3'd2, 0);
    op(3'd0, 0);
    for (int a = 0; a < 4; a++) begin
      op(3'd6, AW'(a));
      chk("id code", a < 2 ? ID_MAN : ID_DEV, d[15:0]);
    end
    for (int i = 0; i < 6; i++) begin
      b = 6'($random(seed));
      op(3'd6, {b, 15'(4 + i % 2)});
      chk("id block status", exp_blk(b), d[15:0] & 16'h0003);
      op(3'd7, {b, 15'h0});
      rd(fq_pkg::REG_BLKSTAT, d);
      chk("block status reg", exp_blk(b), d[15:0]);
      chk("block valid", 16'h1, {15'h0, s[10]});
    end
    op(3'd5, 0);
    op(3'd6, 3);
    chk("array after id", 16'hA5A6, d[15:0]);
    pulse_fail();
    op(3'd2, 0);
    chk("sticky set", 16'h00BA, d[15:0]);
    busy <= 1'b1;
    op(3'd3, 0);
    chk("clear ignored", 16'h1, {15'h0, s[11]});
    op(3'd2, 0);
    chk("busy status", 16'h003A, d[15:0]);
    op(3'd0, 0);
    op(3'd7, 0);
    chk("block invalid", 16'h0, {15'h0, s[10]});
    busy <= 1'b0;
    op(3'd3, 0);
    chk("clear taken", 16'h0, {15'h0, s[11]});
    op(3'd2, 0);
    op(3'd6, 5);
    chk("status cleared", 16'h0080, d[15:0]);
    op(3'd4, 0);
    chk("ext status", 16'h0080, d[15:0]);
    ext <= 8'h00;
    op(3'd6, 0);
    chk("ext held", 16'h0080, d[15:0]);
    op(3'd4, 0);
    chk("ext refreshed", 16'h0000, d[15:0]);
    for (int m = 0; m < 2; m++) begin
      byte_m = m[0];
      op(3'd1, 0);
      rd(fq_pkg::REG_CTRL, s);
      chk("ctrl readback", {13'h0, m[0], 2'h3}, s[15:0]);
      for (int k = 0; k < 5; k++) begin
        b = 6'($random(seed));
        qa = {b, k < 3 ? 15'(16 + k) : 15'(32 + b[4:0])};
        op(3'd6, qa);
        chk("query byte", k == 0 ? 16'h51 : k == 1 ? 16'h52 : k == 2 ? 16'h59 : 16'h0, d[15:0]);
      end
      op(3'd6, {b, 15'h2});
      chk("query block", exp_blk(b), d[15:0] & 16'h0003);
      op(3'd7, {b, 15'h0});
      rd(fq_pkg::REG_BLKSTAT, d);
      chk("query block reg", exp_blk(b), d[15:0]);
    end
    wrap_up();
  end
endmodule // test_fq_host
bind fq_host fq_host_checker #(.AW(AW)) u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in), .flash_addr_out(flash_addr_out),
  .flash_dq_out(flash_dq_out), .flash_dq_oe_out(flash_dq_oe_out), .flash_bank_enable_n_out(flash_bank_enable_n_out),
  .flash_oe_n_out(flash_oe_n_out), .flash_we_n_out(flash_we_n_out));
